// [core/dopt_timer.sv]
// Delayed one-shot pulse timer with AXI4-Lite register access.
// Assumes all pin inputs are synchronous to CORE_CLK_IN; the fast
// oscillator arrives as a one-cycle tick on FAST_TICK_IN.
//
// Notes on behaviour
// - Untriggered period is period_compare plus one source cycles.
// - Active width is end_compare minus wait_compare source cycles.
// - Activation comes wait_compare plus one cycles after start or trigger.
// - Source field: /1,/2,/4,/8,/32, external rise, fast osc; 111 forbidden.
// - Clear-select 0 runs free; 1 clears counter on period match.
// - Polarity 0 idles low, pulses high; polarity 1 inverts all.
// - Only the pulse pin is driven; other level selects do nothing.
// - Trigger field 00: counting starts when run bit is written 1.
// - Trigger field nonzero: edge starts count if running and inactive.
// - Trigger edge is rising, falling or both.
// - Run bit 0 stops, output goes idle, counter value kept.
// - Stop-select 1: period match stops and idles output, one-shot.
// - On that stop counter kept if clear-select 0, zeroed if 1.
// - Five flags: four compare matches and overflow feed one request.
// - Request is set when any flag and its enable are both 1.
// - Request drops once flag or enable drops; it is a level.
// - A further source while requesting leaves the request at 1.
// - Flags are not cleared by acknowledge; software clears them.
// - Fourth-buffer bit 1 makes the buffer hold the next end value.
// - Counter increments per source event; software reads and writes it.
// - Buffer copies to end compare on period match or trigger.
// - Optional filter accepts trigger level after three equal samples.
// - Cutoff enabled: low interrupt pin sets all output disables.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dopt_timer #(
  parameter int FILT_LEN = 3
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [11:0] S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [11:0] S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        TRIG_IN,
  input  wire logic        EXT_CLK_IN,
  input  wire logic        FAST_TICK_IN,
  input  wire logic        EXT_INT_N_IN,
  output logic             PULSE_OUT,
  output logic             PULSE_OE_N_OUT,
  output logic             IRQ_OUT
);
  initial begin
    if (FILT_LEN < 2 || FILT_LEN > 8)
      $error("FILT_LEN must lie between 2 and 8");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [9:0] i);
    mapped = (i inside {dopt_pkg::IDX_MODE, dopt_pkg::IDX_C1,
      dopt_pkg::IDX_IEN, dopt_pkg::IDX_STAT, dopt_pkg::IDX_C2,
      dopt_pkg::IDX_CNT, dopt_pkg::IDX_PER, dopt_pkg::IDX_END,
      dopt_pkg::IDX_WAIT, dopt_pkg::IDX_EBUF, dopt_pkg::IDX_FLT,
      dopt_pkg::IDX_OD});
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic               run_r, bufd_r, stop_sel_r, flt_en_r, cut_en_r;
  logic [7:0]         c1_r;
  logic [1:0]         trg_r;
  logic [4:0]         ien_r, flg_r;
  logic [3:0]         od_r;
  logic [15:0]        cnt_r, per_r, end_r, wait_r, ebuf_r;
  logic               active_r, pulse_r, irq_r;
  dopt_pkg::dopt_st_t st_r;
  logic [4:0]         presc_r;
  logic               ext_prev_r, trig_lvl_r, trig_prev_r;
  logic [FILT_LEN-1:0] flt_sh_r;
  logic               aw_v_r, w_v_r, bvalid_r, rvalid_r;
  logic [9:0]         aw_idx_r;
  logic [31:0]        w_d_r, rdata_r;
  logic [3:0]         w_s_r;
  logic [1:0]         bresp_r, rresp_r;

  logic        we, tick, hit, m_a, m_b, m_c, m_d, trg_en, trig_edge;
  logic        trig_acc, stop_hit, clr_sel, pol;
  logic [9:0]  widx, ridx;
  dopt_pkg::dopt_src_t src;

  assign clr_sel = c1_r[dopt_pkg::C1_CLR_BIT];
  assign pol     = c1_r[dopt_pkg::C1_POL_BIT];
  assign src     = dopt_pkg::dopt_src_t'(c1_r[dopt_pkg::C1_SRC_LSB +: 3]);

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  // Address and data are held separately so either may come first
  assign S_AXI_AWREADY_OUT = !aw_v_r && !bvalid_r;
  assign S_AXI_WREADY_OUT  = !w_v_r && !bvalid_r;
  assign S_AXI_ARREADY_OUT = !rvalid_r;
  assign S_AXI_BVALID_OUT  = bvalid_r;
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_RVALID_OUT  = rvalid_r;
  assign S_AXI_RDATA_OUT   = rdata_r;
  assign S_AXI_RRESP_OUT   = rresp_r;
  assign we   = aw_v_r && w_v_r && !bvalid_r;
  assign widx = aw_idx_r;
  assign ridx = S_AXI_ARADDR_IN[11:2];

  // Write channel capture and response
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      aw_v_r   <= 1'b0;
      w_v_r    <= 1'b0;
      aw_idx_r <= '0;
      w_d_r    <= '0;
      w_s_r    <= '0;
      bvalid_r <= 1'b0;
      bresp_r  <= dopt_pkg::RESP_OK;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_v_r   <= 1'b1;
        aw_idx_r <= S_AXI_AWADDR_IN[11:2];
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_v_r <= 1'b1;
        w_d_r <= S_AXI_WDATA_IN;
        w_s_r <= S_AXI_WSTRB_IN;
      end
      if (we) begin
        aw_v_r   <= 1'b0;
        w_v_r    <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(widx) ? dopt_pkg::RESP_OK : dopt_pkg::RESP_ERR;
      end else if (bvalid_r && S_AXI_BREADY_IN) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= dopt_pkg::RESP_OK;
    end else if (S_AXI_ARVALID_IN && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(ridx) ? dopt_pkg::RESP_OK : dopt_pkg::RESP_ERR;
      unique case (ridx)
        dopt_pkg::IDX_MODE: rdata_r <= {30'h0, bufd_r, run_r};
        dopt_pkg::IDX_C1:   rdata_r <= {24'h0, c1_r};
        dopt_pkg::IDX_IEN:  rdata_r <= {27'h0, ien_r};
        dopt_pkg::IDX_STAT: rdata_r <= {27'h0, flg_r};
        dopt_pkg::IDX_C2:   rdata_r <= {29'h0, trg_r, stop_sel_r};
        dopt_pkg::IDX_CNT:  rdata_r <= {16'h0, cnt_r};
        dopt_pkg::IDX_PER:  rdata_r <= {16'h0, per_r};
        dopt_pkg::IDX_END:  rdata_r <= {16'h0, end_r};
        dopt_pkg::IDX_WAIT: rdata_r <= {16'h0, wait_r};
        dopt_pkg::IDX_EBUF: rdata_r <= {16'h0, ebuf_r};
        dopt_pkg::IDX_FLT:  rdata_r <= {31'h0, flt_en_r};
        dopt_pkg::IDX_OD:   rdata_r <= {24'h0, cut_en_r, 3'h0, od_r};
        default:            rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------
  // Free prescaler; a divided tick fires when the low bits are all ones
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      presc_r    <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      presc_r    <= presc_r + 5'h01;
      ext_prev_r <= EXT_CLK_IN;
    end
  end

  // Source select; code 111 gives no ticks at all
  always_comb begin
    unique case (src)
      dopt_pkg::SRC_DIV1:  tick = 1'b1;
      dopt_pkg::SRC_DIV2:  tick = presc_r[0];
      dopt_pkg::SRC_DIV4:  tick = &presc_r[1:0];
      dopt_pkg::SRC_DIV8:  tick = &presc_r[2:0];
      dopt_pkg::SRC_DIV32: tick = &presc_r;
      dopt_pkg::SRC_EXT:   tick = EXT_CLK_IN && !ext_prev_r;
      dopt_pkg::SRC_FAST:  tick = FAST_TICK_IN;
      dopt_pkg::SRC_BAD:   tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Trigger filter and edge detect
  // ---------------------------------------------------------------
  // Filter trades FILT_LEN cycles of delay for glitch immunity
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      flt_sh_r    <= '0;
      trig_lvl_r  <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      flt_sh_r    <= {flt_sh_r[FILT_LEN-2:0], TRIG_IN};
      trig_prev_r <= trig_lvl_r;
      if (!flt_en_r)
        trig_lvl_r <= TRIG_IN;
      else if (&flt_sh_r)
        trig_lvl_r <= 1'b1;
      else if (~|flt_sh_r)
        trig_lvl_r <= 1'b0;
    end
  end

  assign trg_en = (trg_r != dopt_pkg::TRG_OFF);
  // Edge choice per trigger field
  assign trig_edge =
    (trg_r[0] && trig_lvl_r && !trig_prev_r) ||
    (trg_r[1] && !trig_lvl_r && trig_prev_r);
  // Accepted only while running and the output sits inactive
  assign trig_acc = trg_en && run_r && !active_r && trig_edge;

  // ---------------------------------------------------------------
  // Compare logic
  // ---------------------------------------------------------------
  assign hit      = (st_r == dopt_pkg::ST_RUN) && tick && !trig_acc;
  assign m_a      = (cnt_r == per_r);
  assign m_b      = (cnt_r == end_r);
  assign m_c      = (cnt_r == wait_r);
  assign m_d      = (cnt_r == ebuf_r);
  assign stop_hit = hit && m_a && stop_sel_r;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Level selects of the other channels are stored but drive nothing
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      run_r      <= 1'b0;
      bufd_r     <= 1'b0;
      c1_r       <= dopt_pkg::RST_C1;
      ien_r      <= '0;
      stop_sel_r <= 1'b0;
      trg_r      <= dopt_pkg::TRG_OFF;
      flt_en_r   <= 1'b0;
      per_r      <= dopt_pkg::RST_CMP;
      wait_r     <= dopt_pkg::RST_CMP;
      ebuf_r     <= dopt_pkg::RST_CMP;
    end else begin
      if (we && widx == dopt_pkg::IDX_MODE && w_s_r[0]) begin
        run_r  <= w_d_r[dopt_pkg::MODE_RUN_BIT];
        bufd_r <= w_d_r[dopt_pkg::MODE_BUFD_BIT];
      end
      // Hardware stop wins over a same-cycle software write
      if (stop_hit)
        run_r <= 1'b0;
      if (we && w_s_r[0]) begin
        if (widx == dopt_pkg::IDX_C1) c1_r <= w_d_r[7:0];
        if (widx == dopt_pkg::IDX_IEN) ien_r <= w_d_r[4:0];
        if (widx == dopt_pkg::IDX_FLT)
          flt_en_r <= w_d_r[dopt_pkg::FLT_EN_BIT];
        if (widx == dopt_pkg::IDX_C2) begin
          stop_sel_r <= w_d_r[dopt_pkg::C2_STOP_BIT];
          trg_r      <= w_d_r[dopt_pkg::C2_TRG_LSB +: 2];
        end
      end
      if (we && widx == dopt_pkg::IDX_PER)
        per_r <= lane16(per_r, w_d_r, w_s_r);
      if (we && widx == dopt_pkg::IDX_WAIT)
        wait_r <= lane16(wait_r, w_d_r, w_s_r);
      if (we && widx == dopt_pkg::IDX_EBUF)
        ebuf_r <= lane16(ebuf_r, w_d_r, w_s_r);
    end
  end

  // End compare with buffered reload on period match or trigger
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      end_r <= dopt_pkg::RST_CMP;
    end else if (bufd_r && ((hit && m_a) || trig_acc)) begin
      end_r <= ebuf_r;
    end else if (we && widx == dopt_pkg::IDX_END) begin
      end_r <= lane16(end_r, w_d_r, w_s_r);
    end
  end

  // ---------------------------------------------------------------
  // Counter, run state and pulse level
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_r     <= dopt_pkg::ST_STOP;
      cnt_r    <= '0;
      active_r <= 1'b0;
    end else begin
      if (we && widx == dopt_pkg::IDX_CNT)
        cnt_r <= lane16(cnt_r, w_d_r, w_s_r);
      unique case (st_r)
        dopt_pkg::ST_STOP: begin
          active_r <= 1'b0;
          // An edge in the very cycle after the run write is not lost
          if (run_r && trig_acc) begin
            st_r  <= dopt_pkg::ST_RUN;
            cnt_r <= '0;
          end else if (run_r)
            st_r <= trg_en ? dopt_pkg::ST_ARM : dopt_pkg::ST_RUN;
        end
        dopt_pkg::ST_ARM, dopt_pkg::ST_RUN: begin
          if (!run_r) begin
            st_r     <= dopt_pkg::ST_STOP;
            active_r <= 1'b0;
          end else if (trig_acc) begin
            st_r  <= dopt_pkg::ST_RUN;
            cnt_r <= '0;
          end else if (hit) begin
            if (m_a && clr_sel)
              cnt_r <= '0;
            else if (!stop_hit)
              cnt_r <= cnt_r + 16'h0001;
            if (stop_hit) begin
              st_r     <= dopt_pkg::ST_STOP;
              active_r <= 1'b0;
            end else if (m_b)
              active_r <= 1'b0;
            else if (m_c)
              active_r <= 1'b1;
          end
        end
        default: st_r <= dopt_pkg::ST_STOP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Flags, request, output pin and cutoff
  // ---------------------------------------------------------------
  // Writing 0 clears a flag; a same-cycle event still sets it
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      flg_r <= '0;
    end else begin
      flg_r <= ((we && widx == dopt_pkg::IDX_STAT && w_s_r[0])
                ? (flg_r & w_d_r[4:0]) : flg_r)
             | ({5{hit}} & {cnt_r == dopt_pkg::CNT_MAX && !(m_a && clr_sel),
                            m_d, m_c, m_b, m_a});
    end
  end

  // Cutoff disables; the low pin beats a software re-enable
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      od_r     <= '0;
      cut_en_r <= 1'b0;
    end else begin
      if (we && widx == dopt_pkg::IDX_OD && w_s_r[0]) begin
        od_r     <= w_d_r[3:0];
        cut_en_r <= w_d_r[dopt_pkg::OD_CUT_BIT];
      end
      if (cut_en_r && !EXT_INT_N_IN)
        od_r <= 4'hF;
    end
  end

  // Registered pin level and level request
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pulse_r <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      pulse_r <= active_r ^ pol;
      irq_r   <= |(flg_r & ien_r);
    end
  end

  assign PULSE_OUT      = pulse_r;
  assign PULSE_OE_N_OUT = od_r[dopt_pkg::OD_PULSE_BIT];
  assign IRQ_OUT        = irq_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_stop_match;
    stop_hit;
  endsequence
  sequence s_idle_after;
    !run_r && !active_r ##1 st_r == dopt_pkg::ST_STOP;
  endsequence

  a_oneshot_stop: assert property (s_stop_match |=> s_idle_after)
    else $error("Period stop did not idle the timer");
  a_stop_idle: assert property (!run_r |=> !active_r)
    else $error("Output active while stopped");
  a_trig_restart: assert property (trig_acc |=>
      cnt_r == 16'h0000 && st_r == dopt_pkg::ST_RUN)
    else $error("Trigger did not restart count");
  a_wait_rise: assert property (hit && m_c && !m_b && !stop_hit && run_r
      |=> active_r)
    else $error("Wait match did not activate");
  a_end_fall: assert property (hit && m_b && run_r |=> !active_r)
    else $error("End match did not deactivate");
  a_period_clear: assert property (hit && m_a && clr_sel && run_r
      && !(we && widx == dopt_pkg::IDX_CNT) |=> cnt_r == 16'h0000)
    else $error("Period match did not clear counter");
  a_irq_level: assert property (IRQ_OUT == $past(|(flg_r & ien_r), 1)
      || $past(RESET_IN))
    else $error("Request does not follow flags");
  a_pulse_pol: assert property (##2 PULSE_OUT ==
      ($past(active_r, 1) ^ $past(pol, 1)))
    else $error("Pin level wrong for polarity");
  a_flag_sticky: assert property (!(we && widx == dopt_pkg::IDX_STAT)
      |=> (flg_r & $past(flg_r)) == $past(flg_r))
    else $error("Flag cleared without a write");
  a_cut_fast: assert property (cut_en_r && !EXT_INT_N_IN
      |=> PULSE_OE_N_OUT)
    else $error("Cutoff did not disable output");
endmodule // dopt_timer

// [dv/dopt_partner.sv]
// Far-side model: trigger source, external count clock, fast tick.
// Assumes one clock; every output changes just after a rising edge.
`timescale 1ns/1ps
module dopt_partner (
  input  wire logic clk_in,
  input  wire logic fire_in,
  output logic      trig_out,
  output logic      ext_clk_out,
  output logic      fast_tick_out
);
  logic [2:0] div_r = 3'h0;
  initial trig_out = 1'b0;
  initial fast_tick_out = 1'b0;
  // Level flips on request, so rising and falling edges alternate
  always @(posedge clk_in) begin
    if (fire_in) trig_out <= ~trig_out;
    div_r <= div_r + 3'h1;
    fast_tick_out <= ($urandom % 3) == 0;
  end
  assign ext_clk_out = div_r[2];
endmodule // dopt_partner

// [dv/tb_top.sv]
// Self-checking bench: one-shot pulses, triggers, registers, request.
// Assumes the timer plus the far-side model in dopt_partner.sv.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0;
  logic        arv = 0, rre = 0, fire = 0, pol = 0, intn = 1;
  logic        awr, wrd, bv, arr, rv, pls, oen, irq, trg, ext, fst;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd, r;
  logic [1:0]  br, rr;
  logic [33:0] expq[$];
  int          mismatches = 0, n_checks = 0, cyc = 0, act = 0;
  dopt_timer dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awa),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
    .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rre), .TRIG_IN(trg), .EXT_CLK_IN(ext),
    .FAST_TICK_IN(fst), .EXT_INT_N_IN(intn), .PULSE_OUT(pls),
    .PULSE_OE_N_OUT(oen), .IRQ_OUT(irq));
  dopt_partner far (.clk_in(clk), .fire_in(fire), .trig_out(trg),
    .ext_clk_out(ext), .fast_tick_out(fst));
  // ---------------------------------------------------------------
  // Clock, watchers and shared tasks
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) if (pls !== pol) act++;
  always @(posedge clk) if (rv && rre) chk({rr, rdd}, expq.pop_front());
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) if (++cyc == 20000) begin
    mismatches++;
    print_verdict();
  end
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Ready is sampled at the falling edge, acted on at the next rise
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic ta = 0, tw = 0;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(negedge clk);
      ta = ta | (awv & awr);
      tw = tw | (wv & wrd);
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!(ta && tw));
    do @(negedge clk); while (!bv);
    @(posedge clk);
    bre <= 0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [33:0] e);
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1;
    rre <= 1;
    expq.push_back(e);
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (!rv);
    @(posedge clk);
    rre <= 0;
  endtask
  // Main sequence: reset, four one-shots, request, counter, bus error
  initial begin
    r = $urandom(83);
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(dopt_pkg::IDX_C1, {26'h0, dopt_pkg::RST_C1});
    rd(dopt_pkg::IDX_PER, {18'h0, dopt_pkg::RST_CMP});
    wr(dopt_pkg::IDX_WAIT, 32'h2);
    wr(dopt_pkg::IDX_END, 32'h5);
    wr(dopt_pkg::IDX_PER, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(dopt_pkg::IDX_C1, {24'h0, 6'h20, i[0], 1'b0});
      wr(dopt_pkg::IDX_C2, {29'h0, i[1] ? 2'(i - 1) : 2'b00, 1'b1});
      pol = i[0];
      act = 0;
      wr(dopt_pkg::IDX_MODE, 32'h1);
      if (i[1]) begin
        repeat (5) @(posedge clk);
        chk(34'(act), 34'h0);
        fire <= 1;
        @(posedge clk);
        fire <= 0;
      end
      repeat (40) @(posedge clk);
      chk(34'(act), 34'h3);
      chk({33'h0, pls}, {33'h0, pol});
      rd(dopt_pkg::IDX_CNT, 34'h0);
      rd(dopt_pkg::IDX_MODE, 34'h0);
    end
    rd(dopt_pkg::IDX_STAT, 34'h7);
    wr(dopt_pkg::IDX_IEN, 32'h1 << dopt_pkg::FLG_A);
    @(negedge clk);
    chk({33'h0, irq}, 34'h1);
    wr(dopt_pkg::IDX_IEN, 32'h5);
    @(negedge clk);
    chk({33'h0, irq}, 34'h1);
    wr(dopt_pkg::IDX_STAT, 32'h0);
    @(negedge clk);
    chk({33'h0, irq}, 34'h0);
    r = $urandom;
    wr(dopt_pkg::IDX_CNT, {16'h0, r[15:0]});
    rd(dopt_pkg::IDX_CNT, {18'h0, r[15:0]});
    rd(10'h100, {dopt_pkg::RESP_ERR, 32'h0});
    chk({33'h0, oen}, 34'h0);
    // Cutoff: enable it, then pull the interrupt pin low
    wr(dopt_pkg::IDX_OD, 32'h80);
    intn <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({33'h0, oen}, 34'h1);
    @(negedge clk);
    print_verdict();
  end
endmodule // tb_top

// [shared/dopt_pkg.sv]
// Constants for the delayed one-shot pulse timer: register indices,
// field positions, reset values and encodings.
// Assumes a 32-bit AXI4-Lite slave with byte address = 4 * index.
package dopt_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_MODE = 10'h120;
  localparam logic [9:0] IDX_C1   = 10'h121;
  localparam logic [9:0] IDX_IEN  = 10'h122;
  localparam logic [9:0] IDX_STAT = 10'h123;
  localparam logic [9:0] IDX_C2   = 10'h126;
  localparam logic [9:0] IDX_CNT  = 10'h128;
  localparam logic [9:0] IDX_PER  = 10'h129;
  localparam logic [9:0] IDX_END  = 10'h12A;
  localparam logic [9:0] IDX_WAIT = 10'h12B;
  localparam logic [9:0] IDX_EBUF = 10'h12C;
  localparam logic [9:0] IDX_FLT  = 10'h12D;
  localparam logic [9:0] IDX_OD   = 10'h12E;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_BUFD_BIT = 1;
  localparam int C1_POL_BIT = 1;
  localparam int C1_SRC_LSB = 4;
  localparam int C1_CLR_BIT = 7;
  localparam int C2_STOP_BIT = 0;
  localparam int C2_TRG_LSB = 1;
  localparam int FLT_EN_BIT = 0;
  localparam int OD_PULSE_BIT = 1;
  localparam int OD_CUT_BIT = 7;
  localparam int FLG_A = 0;
  localparam int FLG_B = 1;
  localparam int FLG_C = 2;
  localparam int FLG_D = 3;
  localparam int FLG_OVF = 4;
  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_C1   = 8'h00;
  localparam logic [15:0] RST_CMP  = 16'hFFFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_DIV1 = 3'h0, SRC_DIV2 = 3'h1, SRC_DIV4 = 3'h2, SRC_DIV8 = 3'h3,
    SRC_DIV32 = 3'h4, SRC_EXT = 3'h5, SRC_FAST = 3'h6, SRC_BAD = 3'h7
  } dopt_src_t;
  typedef enum logic [1:0] {
    TRG_OFF = 2'h0, TRG_RISE = 2'h1, TRG_FALL = 2'h2, TRG_BOTH = 2'h3
  } dopt_trg_t;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001, ST_ARM = 3'b010, ST_RUN = 3'b100
  } dopt_st_t;
endpackage
